/* common/frc_orbit_pkg.sv */
// shared constants for the dither and orbit post-processing stage
package gray_orbit_pkg;

	// register port addresses
	localparam logic [7:0] ADDR_FORMAT     = 8'h01;
	localparam logic [7:0] ADDR_HSHIFT     = 8'h02;
	localparam logic [7:0] ADDR_VSHIFT     = 8'h03;
	localparam logic [7:0] ADDR_DITHER     = 8'h05;

	// field positions inside the addressed byte
	localparam int         FORMAT_H_LSB    = 0;
	localparam int         SHIFT_LSB       = 0;
	localparam int         DITHER_BIT      = 0;

	// reset values
	localparam logic [1:0] FORMAT_RESET    = 2'h0;
	localparam logic [4:0] SHIFT_RESET     = 5'h00;
	localparam logic       DITHER_RESET    = 1'b0;

	// horizontal active-width codes
	localparam logic [1:0] FORMAT_640      = 2'h0;
	localparam logic [1:0] FORMAT_532      = 2'h2;

	// shift limits in pixels or lines
	localparam logic signed [4:0] SHIFT_LIM_WIDE = 5'sh0a;
	localparam logic signed [4:0] SHIFT_LIM_640  = 5'sh04;

	// nominal start positions (sync plus back porch)
	localparam logic [9:0] H_START_BASE    = 10'h07a;
	localparam logic [9:0] V_START_BASE    = 10'h026;

	// pixel widths
	localparam int         CHAN_W          = 8;
	localparam int         FRAC_W          = 2;
	localparam int         NUM_CHAN        = 3;
	localparam int         PIX_IN_W        = NUM_CHAN * (CHAN_W + FRAC_W);
	localparam int         PIX_OUT_W       = NUM_CHAN * CHAN_W;

	// buffering
	localparam int         FIFO_DEPTH      = 32;
	localparam int         FIFO_W          = PIX_IN_W + 2;

	// frame phases of the temporal modulation
	localparam int         PHASE_W         = 2;
	localparam logic [1:0] PHASE_RESET     = 2'h0;

endpackage : gray_orbit_pkg

/* design/frc_orbit_top.sv */
// temporal gray modulation and orbit shift stage of the timing controller
`timescale 1ns/1ns
`default_nettype none
module gray_orbit_top
	import gray_orbit_pkg::*;
(
	input  wire logic                 clk_sys_in,    // master clock, 20 MHz
	input  wire logic                 reset_n_in,    // system reset, active low
	input  wire logic                 reg_wr_in,     // register write strobe
	input  wire logic                 reg_rd_in,     // register read strobe
	input  wire logic [7:0]           reg_addr_in,   // register address
	input  wire logic [7:0]           reg_wdata_in,  // register write data
	output logic [7:0]                reg_rdata_out, // register read data
	input  wire logic                 hsync_n_in,    // line sync, active low
	input  wire logic                 vsync_n_in,    // frame sync, active low
	input  wire logic                 pix_valid_in,  // pixel present
	input  wire logic [PIX_IN_W-1:0]  pix_data_in,   // three channels, 8.2 each
	output logic                      pix_ready_out, // pixel accepted
	output logic                      out_valid_out, // output pixel present
	input  wire logic                 out_ready_in,  // downstream takes it
	output logic [PIX_OUT_W-1:0]      out_data_out,  // three 8-bit channels
	output logic                      out_sof_out,   // first pixel of frame
	output logic                      out_sol_out,   // first pixel of line
	output logic [9:0]                h_start_out,   // horizontal start position
	output logic [9:0]                v_start_out,   // vertical start position
	output logic [PHASE_W-1:0]        gray_phase_out // current frame phase
);

	// register file
	logic        dither_enable_ff;
	logic [1:0]  format_h_ff;
	logic [4:0]  horiz_image_shift_ff;
	logic [4:0]  vert_image_shift_ff;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dither_enable_ff     <= DITHER_RESET;
			format_h_ff          <= FORMAT_RESET;
			horiz_image_shift_ff <= SHIFT_RESET;
			vert_image_shift_ff  <= SHIFT_RESET;
		end else if (reg_wr_in) begin
			unique case (reg_addr_in)
				ADDR_DITHER: dither_enable_ff     <= reg_wdata_in[DITHER_BIT];
				ADDR_FORMAT: format_h_ff          <= reg_wdata_in[FORMAT_H_LSB +: 2];
				ADDR_HSHIFT: horiz_image_shift_ff <= reg_wdata_in[SHIFT_LSB +: 5];
				ADDR_VSHIFT: vert_image_shift_ff  <= reg_wdata_in[SHIFT_LSB +: 5];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				ADDR_DITHER: reg_rdata_out <= {7'h00, dither_enable_ff};
				ADDR_FORMAT: reg_rdata_out <= {6'h00, format_h_ff};
				ADDR_HSHIFT: reg_rdata_out <= {3'h0, horiz_image_shift_ff};
				ADDR_VSHIFT: reg_rdata_out <= {3'h0, vert_image_shift_ff};
				default:     reg_rdata_out <= 8'h00;
			endcase
		end
	end

	// shift saturation; undefined format codes take the narrow limit as the safe case
	logic signed [4:0] h_limit;
	logic signed [4:0] h_clamped;
	logic signed [4:0] v_clamped;

	function automatic logic signed [4:0] clamp_shift(input logic signed [4:0] val,
	                                                  input logic signed [4:0] lim);
		logic signed [4:0] res;
		res = val;
		if (val > lim) begin
			res = lim;
		end else if (val < -lim) begin
			res = -lim;
		end
		return res;
	endfunction : clamp_shift

	assign h_limit   = (format_h_ff == FORMAT_532) ? SHIFT_LIM_WIDE : SHIFT_LIM_640;
	assign h_clamped = clamp_shift(horiz_image_shift_ff, h_limit);
	assign v_clamped = clamp_shift(vert_image_shift_ff, SHIFT_LIM_WIDE);

	// input side: sync edges mark the next accepted pixel
	logic              hsync_prev_ff;
	logic              vsync_prev_ff;
	logic              sol_pend_ff;
	logic              sof_pend_ff;
	logic              hs_fall;
	logic              vs_fall;
	logic              in_push;
	logic              fifo_in_ready;
	logic [FIFO_W-1:0] fifo_in_word;

	assign hs_fall       = hsync_prev_ff & ~hsync_n_in;
	assign vs_fall       = vsync_prev_ff & ~vsync_n_in;
	assign pix_ready_out = fifo_in_ready;
	assign in_push       = pix_valid_in & fifo_in_ready;
	assign fifo_in_word  = {sof_pend_ff | vs_fall, sol_pend_ff | hs_fall, pix_data_in};

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hsync_prev_ff <= 1'b1;
			vsync_prev_ff <= 1'b1;
			sol_pend_ff   <= 1'b0;
			sof_pend_ff   <= 1'b0;
		end else begin
			hsync_prev_ff <= hsync_n_in;
			vsync_prev_ff <= vsync_n_in;
			sol_pend_ff   <= (sol_pend_ff | hs_fall) & ~in_push;
			sof_pend_ff   <= (sof_pend_ff | vs_fall) & ~in_push;
		end
	end

	// buffering between the video source and the processing stage
	logic              fifo_out_valid;
	logic              fifo_out_ready;
	logic [FIFO_W-1:0] fifo_out_word;

	pix_fifo #(
		.WIDTH (FIFO_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_sys_in    (clk_sys_in),
		.reset_n_in    (reset_n_in),
		.in_valid_in   (pix_valid_in),
		.in_ready_out  (fifo_in_ready),
		.in_data_in    (fifo_in_word),
		.out_valid_out (fifo_out_valid),
		.out_ready_in  (fifo_out_ready),
		.out_data_out  (fifo_out_word)
	);

	// output stage
	logic               load;
	logic               w_sof;
	logic               w_sol;
	logic [PHASE_W-1:0] phase_ff;
	logic [PHASE_W-1:0] phase_use;
	logic               x_par_ff;
	logic               y_par_ff;
	logic               x_use;
	logic               y_use;
	logic [PHASE_W-1:0] thr;
	logic [PIX_OUT_W-1:0] nxt_out_data;

	assign fifo_out_ready = ~out_valid_out | out_ready_in;
	assign load           = fifo_out_valid & fifo_out_ready;
	assign w_sof          = fifo_out_word[FIFO_W-1];
	assign w_sol          = fifo_out_word[FIFO_W-2];
	assign phase_use      = w_sof ? phase_ff + 1'b1 : phase_ff;
	assign x_use          = (w_sof | w_sol) ? 1'b0 : x_par_ff;
	assign y_use          = w_sof ? 1'b0 : (w_sol ? ~y_par_ff : y_par_ff);
	// spatial offset spreads the bumped pixels so the panel does not flicker as a whole
	assign thr            = phase_use + {y_use, x_use};

	genvar gc;
	generate
		for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
			logic [CHAN_W-1:0] ch_int;
			logic [FRAC_W-1:0] ch_frac;
			logic              bump;
			assign ch_int  = fifo_out_word[gc*(CHAN_W+FRAC_W)+FRAC_W +: CHAN_W];
			assign ch_frac = fifo_out_word[gc*(CHAN_W+FRAC_W) +: FRAC_W];
			// fraction n lights the next code in n of every four frames
			assign bump    = dither_enable_ff & (ch_frac > thr) & (ch_int != 8'hff);
			assign nxt_out_data[gc*CHAN_W +: CHAN_W] = ch_int + {7'h00, bump};
		end
	endgenerate

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			out_valid_out <= 1'b0;
			out_data_out  <= '0;
			out_sof_out   <= 1'b0;
			out_sol_out   <= 1'b0;
		end else begin
			out_valid_out <= load | (out_valid_out & ~out_ready_in);
			if (load) begin
				out_data_out <= nxt_out_data;
				out_sof_out  <= w_sof;
				out_sol_out  <= w_sol;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			phase_ff <= PHASE_RESET;
			x_par_ff <= 1'b0;
			y_par_ff <= 1'b0;
		end else if (load) begin
			phase_ff <= phase_use;
			x_par_ff <= ~x_use;
			y_par_ff <= y_use;
		end
	end

	assign gray_phase_out = phase_ff;

	// shifts take effect at a frame boundary so a frame never tears mid-scan
	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			h_start_out <= H_START_BASE;
			v_start_out <= V_START_BASE;
		end else if (load && w_sof) begin
			h_start_out <= H_START_BASE + {{5{h_clamped[4]}}, h_clamped};
			v_start_out <= V_START_BASE + {{5{v_clamped[4]}}, v_clamped};
		end
	end

	// checks
	sequence sof_load;
		load && w_sof;
	endsequence

	AST_DITHER_OFF: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		load && !dither_enable_ff |=> out_data_out == {$past(fifo_out_word[29:22]),
			$past(fifo_out_word[19:12]), $past(fifo_out_word[9:2])})
		else $error("output changed while dithering is off");

	AST_PHASE_CYCLE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		(sof_load ##0 (phase_ff == 2'h3)) |=> phase_ff == 2'h0)
		else $error("frame phase did not wrap after four frames");

	AST_PHASE_STEP: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		sof_load |=> phase_ff == $past(phase_ff) + 2'h1)
		else $error("frame phase did not step by one");

	AST_NO_BUMP_ZERO_FRAC: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		load && fifo_out_word[1:0] == 2'h0 |=> out_data_out[7:0] == $past(fifo_out_word[9:2]))
		else $error("pixel bumped without fraction");

	AST_FULL_FRAC_BUMP: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		load && dither_enable_ff && fifo_out_word[1:0] == 2'h3 && thr != 2'h3
			&& fifo_out_word[9:2] != 8'hff
		|=> out_data_out[7:0] == $past(fifo_out_word[9:2]) + 8'h01)
		else $error("fraction three missed a bump");

	AST_HREG_RESET: assert property (@(posedge clk_sys_in)
		$rose(reset_n_in) |-> horiz_image_shift_ff == SHIFT_RESET && vert_image_shift_ff == SHIFT_RESET)
		else $error("shift register not cleared by reset");

	AST_H_LIMIT_640: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		format_h_ff == FORMAT_640 |-> h_clamped <= 5'sh04 && h_clamped >= -5'sh04)
		else $error("horizontal shift beyond 640 limit");

	AST_H_START: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		sof_load |=> $signed(h_start_out) - $signed(H_START_BASE) == $past(h_clamped))
		else $error("horizontal start not moved by shift");

	AST_V_START: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		sof_load |=> $signed(v_start_out) - $signed(V_START_BASE) == $past(v_clamped))
		else $error("vertical start not moved by shift");

	AST_SATURATE: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		$signed(vert_image_shift_ff) > 5'sh0a |-> v_clamped == 5'sh0a)
		else $error("vertical shift not saturated");

endmodule : gray_orbit_top
`default_nettype wire

/* design/pix_fifo.sv */
// pixel fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module pix_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_sys_in,    // master clock
	input  wire logic             reset_n_in,    // async reset, active low
	input  wire logic             in_valid_in,   // write side has data
	output logic                  in_ready_out,  // room for one word
	input  wire logic [WIDTH-1:0] in_data_in,    // word to store
	output logic                  out_valid_out, // a word is available
	input  wire logic             out_ready_in,  // reader takes the word
	output logic [WIDTH-1:0]      out_data_out   // oldest word
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wptr_ff;
	logic [AW-1:0]    rptr_ff;
	logic [AW:0]      count_ff;
	logic             push;
	logic             pop;

	assign in_ready_out  = (count_ff != DEPTH[AW:0]);
	assign out_valid_out = (count_ff != '0);
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;
	assign out_data_out  = mem_ff[rptr_ff];

	always_ff @(posedge clk_sys_in) begin
		if (push) begin
			mem_ff[wptr_ff] <= in_data_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			wptr_ff  <= '0;
			rptr_ff  <= '0;
			count_ff <= '0;
		end else begin
			if (push) begin
				wptr_ff <= wptr_ff + 1'b1;
			end
			if (pop) begin
				rptr_ff <= rptr_ff + 1'b1;
			end
			if (push && !pop) begin
				count_ff <= count_ff + 1'b1;
			end else if (pop && !push) begin
				count_ff <= count_ff - 1'b1;
			end
		end
	end

	AST_FIFO_NO_OVERFLOW: assert property (@(posedge clk_sys_in) disable iff (!reset_n_in)
		count_ff <= DEPTH[AW:0])
		else $error("fifo count above depth");

endmodule : pix_fifo
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the dither and orbit stage
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s exp %h got %h", nm, e, g); end end
module tb_top
	import gray_orbit_pkg::*;
;
	typedef struct packed {logic [PIX_IN_W-1:0] px; logic sof; logic sol; logic dith;} note_s;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 wr_en = 1'b0;
	logic                 rd_en = 1'b0;
	logic [7:0]           addr = 8'h00;
	logic [7:0]           wdata = 8'h00;
	logic [7:0]           rdata;
	logic                 hs_n, vs_n, pv, prdy, ov, sof, sol, busy;
	logic [PIX_IN_W-1:0]  pdata;
	logic [PIX_IN_W-1:0]  base = '0;
	logic [PIX_IN_W-1:0]  mask = '0;
	logic [PIX_OUT_W-1:0] odata;
	logic [9:0]           hst, vst;
	logic [PHASE_W-1:0]   phase;
	logic                 ordy = 1'b0;
	logic                 hold_rdy = 1'b0;
	logic                 go = 1'b0;
	logic                 slow = 1'b0;
	logic                 dith_on = 1'b0;
	logic [3:0]           nlines = 4'h1;
	logic [5:0]           npix = 6'h01;
	int                   bad_count = 0;
	int                   n_compared = 0;
	int                   acc_cnt = 0;
	int                   dsum = 0;
	int                   fsum = 0;
	note_s                exp_q[$];
	logic [1:0]           t_fmt [5] = '{FORMAT_640, FORMAT_640, FORMAT_640, FORMAT_532, FORMAT_532};
	logic [4:0]           t_h [5] = '{5'h03, 5'h1c, 5'h04, 5'h16, 5'h0f};
	logic [4:0]           t_v [5] = '{5'h16, 5'h0a, 5'h0c, 5'h13, 5'h00};
	int                   t_ho [5] = '{3, -4, 4, -10, 10};
	int                   t_vo [5] = '{-10, 10, 10, -10, 0};

	always #25 clk = ~clk;

	gray_orbit_top uut (.clk_sys_in(clk), .reset_n_in(rst_n), .reg_wr_in(wr_en),
		.reg_rd_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.hsync_n_in(hs_n), .vsync_n_in(vs_n), .pix_valid_in(pv), .pix_data_in(pdata),
		.pix_ready_out(prdy), .out_valid_out(ov), .out_ready_in(ordy), .out_data_out(odata),
		.out_sof_out(sof), .out_sol_out(sol), .h_start_out(hst), .v_start_out(vst),
		.gray_phase_out(phase));
	video_src src (.clk_sys_in(clk), .go_in(go), .slow_in(slow), .lines_in(nlines),
		.pix_in(npix), .base_in(base), .mask_in(mask), .pix_ready_in(prdy),
		.hsync_n_out(hs_n), .vsync_n_out(vs_n), .pix_valid_out(pv), .pix_data_out(pdata),
		.busy_out(busy));

	// note each pixel the moment the coming edge will take it
	always begin
		@(negedge clk);
		#1;
		if (pv && prdy) begin
			exp_q.push_back(note_s'{pdata, !vs_n, !hs_n, dith_on});
			acc_cnt++;
		end
	end

	always @(negedge clk) begin : mon
		note_s      e;
		logic [7:0] gi, ii;
		ordy = !hold_rdy && ($urandom_range(3, 0) != 0);
		if (ov && ordy) begin
			`CHK("note queued", 1'b1, exp_q.size() != 0)
		end
		if (ov && ordy && exp_q.size() != 0) begin
			e = exp_q.pop_front();
			`CHK("sof", e.sof, sof)
			`CHK("sol", e.sol, sol)
			for (int c = 0; c < NUM_CHAN; c++) begin
				gi = odata[c*CHAN_W +: CHAN_W];
				ii = e.px[c*(CHAN_W+FRAC_W)+FRAC_W +: CHAN_W];
				if (!e.dith) `CHK("pixel", ii, gi)
				else begin
					`CHK("dither step", 1'b1, (gi === ii) || (ii != 8'hff && gi === ii + 8'h01))
					dsum += int'(gi) - int'(ii);
					if (ii != 8'hff) fsum += int'(e.px[c*(CHAN_W+FRAC_W) +: FRAC_W]);
				end
			end
		end
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		`CHK("reg read", e, rdata)
	endtask : rd_chk

	task automatic frame(input int nl, input int np, input logic [PIX_IN_W-1:0] b);
		@(negedge clk);
		nlines = 4'(nl);
		npix = 6'(np);
		base = b;
		go = 1'b1;
		@(negedge clk);
		go = 1'b0;
	endtask : frame

	task automatic drain;
		int n;
		n = 0;
		while ((busy || exp_q.size() != 0) && n < 3000) begin
			@(negedge clk);
			#2;
			n++;
		end
		`CHK("drain", 1'b1, n < 3000)
		repeat (3) @(negedge clk);
	endtask : drain

	task automatic final_report;
		if (bad_count == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : final_report

	initial begin
		#(50 * 40000);
		bad_count++;
		final_report();
	end

	initial begin
		logic [PIX_IN_W-1:0] b;
		int                  n;
		void'($urandom(32'h0819_9310));
		repeat (12) @(negedge clk);
		`CHK("h start reset", H_START_BASE, hst)
		`CHK("v start reset", V_START_BASE, vst)
		rst_n = 1'b1;
		rd_chk(ADDR_FORMAT, 8'h00);
		rd_chk(ADDR_HSHIFT, 8'h00);
		rd_chk(ADDR_VSHIFT, 8'h00);
		rd_chk(ADDR_DITHER, 8'h00);
		wr(8'h04, 8'h5a);
		rd_chk(8'h04, 8'h00);
		wr(ADDR_HSHIFT, 8'hff);
		rd_chk(ADDR_HSHIFT, 8'h1f);
		wr(ADDR_DITHER, 8'hff);
		rd_chk(ADDR_DITHER, 8'h01);
		wr(ADDR_FORMAT, 8'hff);
		rd_chk(ADDR_FORMAT, 8'h03);
		wr(ADDR_DITHER, 8'h00);
		// 640 entries stay within four as the host must; entry 4 exceeds ten to see the clamp
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_FORMAT, {6'h00, t_fmt[i]});
			wr(ADDR_HSHIFT, {3'h0, t_h[i]});
			wr(ADDR_VSHIFT, {3'h0, t_v[i]});
			slow = i[0];
			frame(2, 3, PIX_IN_W'($urandom));
			drain();
			`CHK("h start", H_START_BASE + 10'(t_ho[i]), hst)
			`CHK("v start", V_START_BASE + 10'(t_vo[i]), vst)
			`CHK("frame phase", 2'(i + 1), phase)
		end
		wr(ADDR_DITHER, 8'h01);
		dith_on = 1'b1;
		mask = PIX_IN_W'(10'h3ff);
		b = PIX_IN_W'($urandom);
		repeat (4) begin
			frame(2, 4, b);
			drain();
		end
		// fsum adds each fraction once per frame, dsum adds the bumps of all four frames
		`CHK("dither average", fsum, 4 * dsum)
		`CHK("frame phase", 2'h1, phase)
		wr(ADDR_DITHER, 8'h00);
		dith_on = 1'b0;
		mask = '0;
		#5;
		hold_rdy = 1'b1;
		acc_cnt = 0;
		frame(1, 40, PIX_IN_W'($urandom));
		n = 0;
		while (prdy && n < 200) begin
			@(negedge clk);
			n++;
		end
		repeat (4) @(negedge clk);
		`CHK("fill count", 1'b1, acc_cnt >= FIFO_DEPTH && acc_cnt <= FIFO_DEPTH + 1)
		`CHK("ready when full", 1'b0, prdy)
		#5;
		hold_rdy = 1'b0;
		drain();
		final_report();
	end
endmodule : tb_top
`default_nettype wire

/* tb/video_src.sv */
// video source model: parallel pixels with line and frame syncs
`timescale 1ns/1ns
`default_nettype none
module video_src
	import gray_orbit_pkg::*;
(
	input  wire logic                clk_sys_in,    // master clock
	input  wire logic                go_in,         // start a frame
	input  wire logic                slow_in,       // insert random gaps
	input  wire logic [3:0]          lines_in,      // lines per frame
	input  wire logic [5:0]          pix_in,        // pixels per line
	input  wire logic [PIX_IN_W-1:0] base_in,       // pixel seed
	input  wire logic [PIX_IN_W-1:0] mask_in,       // bits forced high
	input  wire logic                pix_ready_in,  // device accepts
	output logic                     hsync_n_out,   // line sync
	output logic                     vsync_n_out,   // frame sync
	output logic                     pix_valid_out, // pixel present
	output logic [PIX_IN_W-1:0]      pix_data_out,  // pixel word
	output logic                     busy_out       // frame in progress
);
	task automatic idle;
		pix_valid_out = 1'b0;
		hsync_n_out = 1'b1;
		vsync_n_out = 1'b1;
		// released data toggles so nothing relies on a stale word
		pix_data_out = ~pix_data_out;
	endtask : idle
	initial begin
		pix_data_out = '0;
		busy_out = 1'b0;
		idle();
		forever begin
			@(posedge clk_sys_in);
			if (go_in) begin
				busy_out = 1'b1;
				@(negedge clk_sys_in);
				for (int l = 0; l < int'(lines_in); l++) begin
					for (int p = 0; p < int'(pix_in); p++) begin
						vsync_n_out = !(l == 0 && p == 0);
						hsync_n_out = (p != 0);
						pix_valid_out = 1'b1;
						// repeatable per position so frames can be averaged
						pix_data_out = (base_in + PIX_IN_W'(p * 4999 + l * 733)) | mask_in;
						while (!pix_ready_in) @(negedge clk_sys_in);
						@(posedge clk_sys_in);
						if (l == int'(lines_in) - 1 && p == int'(pix_in) - 1) busy_out = 1'b0;
						@(negedge clk_sys_in);
						if (slow_in && $urandom_range(1, 0) == 1) begin
							idle();
							@(negedge clk_sys_in);
						end
					end
				end
				idle();
			end
		end
	end
endmodule : video_src
`default_nettype wire
